// ===== rtl/eth_rx_pattern_filter_cfg.svh
// register map, field positions, reset values and limits of the receive filter
//
// Operation
// [RULE1] hash_filter_enable at bit 15 turns hash-table acceptance on or off.
// [RULE2] magic_filter_enable at bit 14 turns wake-up packet acceptance on or off.
// [RULE3] pattern_invert clear needs checksum match; set needs checksum mismatch.
// [RULE4] pattern_match_mode is four bits wide at bits 11 down to 8.
// [RULE5] mode 0000 disables pattern matching; the match always fails.
// [RULE6] checksum term is pattern_invert XOR checksum match; mode 0001 uses it alone.
// [RULE7] modes 0010 and 0011 need checksum term and station address hit.
// [RULE8] modes 0100 and 0101 need checksum term and a unicast destination.
// [RULE9] modes 0110 and 0111 need checksum term and broadcast destination.
// [RULE10] mode 1000 needs checksum term and a hash-table hit.
// [RULE11] mode 1001 needs checksum term and a wake-up packet.
// [RULE12] hash hit inside pattern matching ignores hash_filter_enable.
// [RULE13] wake-up hit inside pattern matching ignores magic_filter_enable.
// [RULE14] the register steers receive only, never transmission.
// [RULE15] software changes the register only while receive_enable is low.
// [RULE16] bits 31 to 16 and bit 13 are unimplemented and read zero.
// [RULE17] crc_valid_required keeps good-CRC frames; crc_error_collect keeps bad-CRC ones.
// [RULE18] runts are under 64 bytes; runt_reject drops them, runt_collect keeps only them.
// [RULE19] four address enables admit station, other unicast, multicast, broadcast.
// [RULE20] implemented bits reset to zero: no pattern match, no acceptance.
`ifndef ETH_RX_PATTERN_FILTER_CFG_SVH
`define ETH_RX_PATTERN_FILTER_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RXF_CFG_ADDR      4'h0
`define RXF_STAT_ADDR     4'h4

// ----------------------------------------------------------------
// rx_filter_config fields
// ----------------------------------------------------------------
`define RXF_HASH_EN_BIT   15
`define RXF_MAGIC_EN_BIT  14
`define RXF_INVERT_BIT    12
`define RXF_MODE_MSB      11
`define RXF_MODE_LSB      8
`define RXF_CRC_ERR_BIT   7
`define RXF_CRC_OK_BIT    6
`define RXF_RUNT_COL_BIT  5
`define RXF_RUNT_REJ_BIT  4
`define RXF_UC_BIT        3
`define RXF_NOTME_BIT     2
`define RXF_MC_BIT        1
`define RXF_BC_BIT        0
`define RXF_CFG_MASK      32'h0000_DFFF
`define RXF_CFG_RESET     32'h0000_0000

// ----------------------------------------------------------------
// pattern match modes and limits
// ----------------------------------------------------------------
`define PM_OFF            4'h0
`define PM_CSUM           4'h1
`define PM_STATION_A      4'h2
`define PM_STATION_B      4'h3
`define PM_UNICAST_A      4'h4
`define PM_UNICAST_B      4'h5
`define PM_BCAST_A        4'h6
`define PM_BCAST_B        4'h7
`define PM_HASH           4'h8
`define PM_WAKEUP         4'h9
`define RUNT_BYTES        16'h0040
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ===== rtl/eth_rx_pattern_filter_pkg.sv
// types shared by the receive filter and its users
package eth_rx_pattern_filter_pkg;

  // ----------------------------------------------------------------
  // frame summary from the receive datapath
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] length;      // frame length in bytes
    logic        crc_ok;      // frame check sequence is valid
    logic        da_station;  // destination equals station address
    logic        da_group;    // destination group bit (multicast or broadcast)
    logic        da_bcast;    // destination is all ones
    logic        csum_match;  // pattern checksum matched
    logic        hash_hit;    // hash table lookup hit
    logic        wakeup_hit;  // frame is a wake-up packet
  } frame_info_t;

  // ----------------------------------------------------------------
  // verdict handed back, one per frame
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic accept;
    logic pattern_ok;
  } verdict_t;

endpackage

// ===== rtl/eth_rx_pattern_filter.sv
// receive frame acceptance filter with its AXI4-Lite register slave
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "eth_rx_pattern_filter_cfg.svh"

module eth_rx_pattern_filter
(
  input  wire logic                                sys_clk_i,
  input  wire logic                                nrst_i,
  input  wire logic [3:0]                          s_axi_awaddr_i,
  input  wire logic                                s_axi_awvalid_i,
  output logic                                     s_axi_awready_o,
  input  wire logic [31:0]                         s_axi_wdata_i,
  input  wire logic [3:0]                          s_axi_wstrb_i,
  input  wire logic                                s_axi_wvalid_i,
  output logic                                     s_axi_wready_o,
  output logic [1:0]                               s_axi_bresp_o,
  output logic                                     s_axi_bvalid_o,
  input  wire logic                                s_axi_bready_i,
  input  wire logic [3:0]                          s_axi_araddr_i,
  input  wire logic                                s_axi_arvalid_i,
  output logic                                     s_axi_arready_o,
  output logic [31:0]                              s_axi_rdata_o,
  output logic [1:0]                               s_axi_rresp_o,
  output logic                                     s_axi_rvalid_o,
  input  wire logic                                s_axi_rready_i,
  input  wire logic                                receive_enable_i,
  input  wire logic                                frame_valid_i,
  input  wire eth_rx_pattern_filter_pkg::frame_info_t frame_i,
  output eth_rx_pattern_filter_pkg::verdict_t      verdict_o
);
  import eth_rx_pattern_filter_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] cfg;
  logic [31:0] next_cfg;
  logic        aw_held;
  logic        next_aw_held;
  logic [3:0]  aw_addr;
  logic [3:0]  next_aw_addr;
  logic        w_held;
  logic        next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;
  logic [3:0]  next_w_strb;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  verdict_t    next_verdict;
  logic [7:0]  accept_cnt;
  logic [7:0]  next_accept_cnt;
  logic [7:0]  reject_cnt;
  logic [7:0]  next_reject_cnt;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  logic [3:0] pm_mode;
  logic       pm_invert;
  logic       csum_term;
  logic       pm_ok;
  logic       is_runt;
  logic       runt_for_collect;
  logic       crc_pass;
  logic       runt_pass;
  logic       addr_pass;
  logic       unicast;

  // mode occupies a four bit field
  assign pm_mode   = cfg[`RXF_MODE_MSB:`RXF_MODE_LSB]; // RULE4
  assign pm_invert = cfg[`RXF_INVERT_BIT];

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // pattern verdict; hash and wake-up hits are taken raw, without enables
  function automatic logic pattern_result(input logic [3:0] mode,
                                          input logic term,
                                          input frame_info_t f);
    logic r;
    r = 1'b0;
    case (mode)
      `PM_OFF:       r = 1'b0;                 // RULE5
      `PM_CSUM:      r = term;                 // RULE6
      `PM_STATION_A,
      `PM_STATION_B: r = term & f.da_station;  // RULE7
      `PM_UNICAST_A,
      `PM_UNICAST_B: r = term & ~f.da_group;   // RULE8
      `PM_BCAST_A,
      `PM_BCAST_B:   r = term & f.da_bcast;    // RULE9
      `PM_HASH:      r = term & f.hash_hit;    // RULE10 RULE12
      `PM_WAKEUP:    r = term & f.wakeup_hit;  // RULE11 RULE13
      default:       r = 1'b0;
    endcase
    return r;
  endfunction

  // register offset decode, shared by both bus directions
  function automatic logic [1:0] reg_sel(input logic [3:0] addr);
    logic [1:0] s;
    s = 2'h0;
    if ({addr[3:2], 2'h0} == `RXF_CFG_ADDR)
      s = 2'h1;
    else if ({addr[3:2], 2'h0} == `RXF_STAT_ADDR)
      s = 2'h2;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // frame judgement
  // ----------------------------------------------------------------

  // only receive frames are judged; nothing here reaches transmit logic
  always_comb
  begin
    csum_term = pm_invert ^ frame_i.csum_match;                 // RULE3 RULE6
    pm_ok     = pattern_result(pm_mode, csum_term, frame_i);    // RULE14
    unicast   = ~frame_i.da_group;
    is_runt   = frame_i.length < `RUNT_BYTES;                   // RULE18
    // with crc checking on, only good-crc short frames count for collection
    runt_for_collect = is_runt & (frame_i.crc_ok | ~cfg[`RXF_CRC_OK_BIT]);
    crc_pass  = ~(cfg[`RXF_CRC_OK_BIT] & ~frame_i.crc_ok)       // RULE17
              & ~(cfg[`RXF_CRC_ERR_BIT] & frame_i.crc_ok);
    runt_pass = ~(cfg[`RXF_RUNT_REJ_BIT] & is_runt)             // RULE18
              & ~(cfg[`RXF_RUNT_COL_BIT] & ~runt_for_collect);
    addr_pass = (cfg[`RXF_UC_BIT] & unicast & frame_i.da_station)       // RULE19
              | (cfg[`RXF_NOTME_BIT] & unicast & ~frame_i.da_station)
              | (cfg[`RXF_MC_BIT] & frame_i.da_group & ~frame_i.da_bcast)
              | (cfg[`RXF_BC_BIT] & frame_i.da_bcast)
              | (cfg[`RXF_HASH_EN_BIT] & frame_i.hash_hit)               // RULE1
              | (cfg[`RXF_MAGIC_EN_BIT] & frame_i.wakeup_hit)            // RULE2
              | pm_ok;
  end

  // verdict and frame counters
  always_comb
  begin
    next_verdict.valid      = frame_valid_i;
    next_verdict.accept     = frame_valid_i & crc_pass & runt_pass & addr_pass;
    next_verdict.pattern_ok = frame_valid_i & pm_ok;
    next_accept_cnt         = accept_cnt;
    next_reject_cnt         = reject_cnt;
    if (frame_valid_i)
    begin
      if (next_verdict.accept)
        next_accept_cnt = accept_cnt + 8'h01;
      else
        next_reject_cnt = reject_cnt + 8'h01;
    end
  end

  // counters wrap; software takes differences
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      verdict_o  <= '0;
      accept_cnt <= 8'h00;
      reject_cnt <= 8'h00;
    end
    else
    begin
      verdict_o  <= next_verdict;
      accept_cnt <= next_accept_cnt;
      reject_cnt <= next_reject_cnt;
    end
  end

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------

  // address and data are caught in either order, then applied together
  always_comb
  begin
    next_cfg     = cfg;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid_o;
    next_bresp   = s_axi_bresp_o;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (s_axi_bvalid_o && s_axi_bready_i)
      next_bvalid = 1'b0;
    if (aw_held && w_held && !s_axi_bvalid_o)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `RESP_OKAY;
      // writes go through even with receive running; software must hold off
      if (reg_sel(aw_addr) == 2'h1)
      begin
        for (int b = 0; b < 4; b++)
          if (w_strb[b])
            next_cfg[8*b +: 8] = w_data[8*b +: 8];
        next_cfg = next_cfg & `RXF_CFG_MASK;                   // RULE15 RULE16
      end
      else if (reg_sel(aw_addr) == 2'h0)
        next_bresp = `RESP_SLVERR;
    end
    // ready stays low while a word waits or a response is pending
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
  end

  // configuration clears to zero: all filters off
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg             <= `RXF_CFG_RESET;                       // RULE20
      aw_held         <= 1'b0;
      aw_addr         <= 4'h0;
      w_held          <= 1'b0;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `RESP_OKAY;
    end
    else
    begin
      cfg             <= next_cfg;
      aw_held         <= next_aw_held;
      aw_addr         <= next_aw_addr;
      w_held          <= next_w_held;
      w_data          <= next_w_data;
      w_strb          <= next_w_strb;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o  <= next_wready;
      s_axi_bvalid_o  <= next_bvalid;
      s_axi_bresp_o   <= next_bresp;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign status_word = {8'h00, reject_cnt, accept_cnt, 5'h00,
                        receive_enable_i, verdict_o.pattern_ok, verdict_o.accept};

  // one read at a time; arready drops while data waits
  always_comb
  begin
    next_rvalid = s_axi_rvalid_o;
    next_rdata  = s_axi_rdata_o;
    next_rresp  = s_axi_rresp_o;
    if (s_axi_rvalid_o && s_axi_rready_i)
      next_rvalid = 1'b0;
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      case (reg_sel(s_axi_araddr_i))
        2'h1:    next_rdata = cfg & `RXF_CFG_MASK;            // RULE16
        2'h2:    next_rdata = status_word;
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o  <= next_rvalid;
      s_axi_rdata_o   <= next_rdata;
      s_axi_rresp_o   <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_mode_off;
    frame_valid_i && pm_mode == `PM_OFF |=> !verdict_o.pattern_ok;
  endproperty
  a_mode_off: assert property (p_mode_off) // RULE5
    else $error("pattern matched with mode off");

  property p_csum_only;
    frame_valid_i && pm_mode == `PM_CSUM |=> verdict_o.pattern_ok == $past(csum_term);
  endproperty
  a_csum_only: assert property (p_csum_only) // RULE6
    else $error("checksum-only mode verdict wrong");

  property p_invert;
    frame_valid_i && pm_mode == `PM_CSUM && pm_invert && frame_i.csum_match
      |=> !verdict_o.pattern_ok;
  endproperty
  a_invert: assert property (p_invert) // RULE3
    else $error("inverted match accepted a matching checksum");

  property p_hash_mode;
    frame_valid_i && pm_mode == `PM_HASH && !frame_i.hash_hit |=> !verdict_o.pattern_ok;
  endproperty
  a_hash_mode: assert property (p_hash_mode) // RULE10
    else $error("hash mode matched without hash hit");

  property p_crc_req;
    frame_valid_i && cfg[`RXF_CRC_OK_BIT] && !frame_i.crc_ok |=> !verdict_o.accept;
  endproperty
  a_crc_req: assert property (p_crc_req) // RULE17
    else $error("bad crc frame accepted");

  property p_runt_rej;
    frame_valid_i && cfg[`RXF_RUNT_REJ_BIT] && frame_i.length < `RUNT_BYTES
      |=> !verdict_o.accept;
  endproperty
  a_runt_rej: assert property (p_runt_rej) // RULE18
    else $error("runt accepted while rejecting runts");

  property p_bcast;
    frame_valid_i && cfg[`RXF_BC_BIT] && frame_i.da_bcast && cfg[7:4] == 4'h0
      |=> verdict_o.valid && verdict_o.accept;
  endproperty
  a_bcast: assert property (p_bcast) // RULE19
    else $error("broadcast frame not accepted");

  property p_unimpl;
    (cfg & ~`RXF_CFG_MASK) == 32'h0000_0000;
  endproperty
  a_unimpl: assert property (p_unimpl) // RULE16
    else $error("unimplemented configuration bit set");

  property p_write_resp;
    aw_held && w_held && !s_axi_bvalid_o |=> s_axi_bvalid_o ##0 !aw_held;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response late");

endmodule

// ===== bench/rx_frame_source.sv
// receive datapath model that hands frame summaries to the filter
`timescale 1ns/1ns

module rx_frame_source
(
  input  wire logic                               sys_clk_i,
  input  wire logic                               slow_i,
  output logic                                    frame_valid_o,
  output eth_rx_pattern_filter_pkg::frame_info_t  frame_o
);
  import eth_rx_pattern_filter_pkg::*;

  frame_info_t pending[$];
  logic        rest;

  initial
  begin
    frame_valid_o = 1'b0;
    frame_o       = '0;
    rest          = 1'b0;
  end

  // one summary a cycle; slow mode leaves an idle cycle between frames
  always @(posedge sys_clk_i)
  begin
    if (pending.size() > 0 && !rest)
    begin
      frame_valid_o <= 1'b1;
      frame_o       <= pending.pop_front();
      rest          <= slow_i;
    end
    else
    begin
      // idle lines wander so a stale summary never looks fresh
      frame_valid_o <= 1'b0;
      frame_o       <= ~frame_o;
      rest          <= 1'b0;
    end
  end
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the receive frame acceptance filter
`timescale 1ns/1ns
`include "eth_rx_pattern_filter_cfg.svh"

module tb_top;
  import eth_rx_pattern_filter_pkg::*;

  logic        sys_clk;
  logic        nrst;
  logic [3:0]  awaddr;
  logic [3:0]  wstrb;
  logic [7:0]  exp_acc;
  logic [7:0]  exp_rej;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        rx_en;
  logic        slow;
  logic        frame_valid;
  frame_info_t frame;
  verdict_t    verdict;
  logic [1:0]  exp_q[$];
  logic [31:0] seed;
  int          failures;
  int          checks;

  eth_rx_pattern_filter uut (.sys_clk_i(sys_clk), .nrst_i(nrst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .receive_enable_i(rx_en),
    .frame_valid_i(frame_valid), .frame_i(frame), .verdict_o(verdict));

  rx_frame_source src (.sys_clk_i(sys_clk), .slow_i(slow), .frame_valid_o(frame_valid),
    .frame_o(frame));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // 32 galois steps per call so successive values are not shifted copies
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int k = 0; k < 32; k++)
      s = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    return s;
  endfunction

  // expected {accept, pattern_ok} worked out independently of the design
  function automatic logic [1:0] expect_v(input logic [31:0] c, input frame_info_t f);
    logic term, uni, runt, pm, gate, hit;
    term = c[12] ^ f.csum_match;
    uni  = !f.da_group;
    runt = f.length < 16'h0040;
    case (c[11:8])
      4'h1: pm = term;
      4'h2, 4'h3: pm = term & f.da_station;
      4'h4, 4'h5: pm = term & uni;
      4'h6, 4'h7: pm = term & f.da_bcast;
      4'h8: pm = term & f.hash_hit;
      4'h9: pm = term & f.wakeup_hit;
      default: pm = 1'b0;
    endcase
    gate = (!c[6] | f.crc_ok) & (!c[7] | !f.crc_ok) & (!c[4] | !runt)
         & (!c[5] | (runt & (!c[6] | f.crc_ok)));
    hit  = (c[3] & uni & f.da_station) | (c[2] & uni & !f.da_station)
         | (c[1] & f.da_group & !f.da_bcast) | (c[0] & f.da_bcast)
         | (c[15] & f.hash_hit) | (c[14] & f.wakeup_hit) | pm;
    return {gate & hit, pm};
  endfunction

  task axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int  n;
    bit  aw_done;
    bit  w_done;
    aw_done = 0;
    w_done  = 0;
    n       = 0;
    @(posedge sys_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done) && n < 50)
    begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready === 1'b1) begin aw_done = 1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin w_done = 1; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    // a response that never came counts against the run
    if (bvalid !== 1'b1)
      failures++;
    r = bresp;
    bready <= 1'b0;
  endtask

  task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    if (rvalid !== 1'b1)
      failures++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // queue a burst of eight random frames and their expected verdicts
  task send_burst(input logic [31:0] c);
    frame_info_t f;
    logic [31:0] r;
    logic [1:0]  e;
    int          n;
    @(negedge sys_clk);
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      r    = seed;
      case (r[1:0])
        2'h0: f.length = 16'h003F;
        2'h1: f.length = 16'h0040;
        2'h2: f.length = {2'h0, r[31:18]};
        default: f.length = {10'h000, r[23:18]};
      endcase
      f.crc_ok     = r[2];
      f.da_group   = r[3];
      f.da_bcast   = r[3] & r[4];
      f.da_station = !r[3] & r[5];
      f.csum_match = r[6];
      f.hash_hit   = r[7];
      f.wakeup_hit = r[8];
      e = expect_v(c, f);
      exp_q.push_back(e);
      // running totals mirror the status counters, wrapping at eight bits
      if (e[1])
        exp_acc = exp_acc + 8'h01;
      else
        exp_rej = exp_rej + 8'h01;
      src.pending.push_back(f);
    end
    n = 0;
    while (exp_q.size() > 0 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (exp_q.size() > 0)
      failures++;
  endtask

  // ----------------------------------------------------------------
  // clock, reset, watchdog, verdict monitor
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // the whole run needs under 2000 cycles; this leaves ample margin
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    end_sim();
  end

  // sample on the falling edge where the registered verdict has settled
  always @(negedge sys_clk)
  begin
    if (nrst === 1'b1 && verdict.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected verdict", 32'h1, 32'h0);
      else
      begin
        logic [1:0] e;
        e = exp_q.pop_front();
        check("accept", {31'h0, verdict.accept}, {31'h0, e[1]});
        check("pattern_ok", {31'h0, verdict.pattern_ok}, {31'h0, e[0]});
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [31:0] c;
    logic [1:0]  r;
    nrst = 1'b0; awaddr = 4'h0; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0;
    bready = 1'b0; araddr = 4'h0; arvalid = 1'b0; rready = 1'b0;
    rx_en = 1'b0; slow = 1'b0; seed = 32'h3F01; failures = 0; checks = 0;
    wstrb = 4'hF; exp_acc = 8'h00; exp_rej = 8'h00;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    axi_read(`RXF_CFG_ADDR, d, r);
    check("cfg reset", d, 32'h0000_0000);
    axi_read(4'h8, d, r);
    check("unmapped read resp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    check("unmapped read data", d, 32'h0);
    axi_write(4'hC, 32'hFFFF_FFFF, r);
    check("unmapped write resp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    // only the low byte lane is enabled, the rest of the word must stay clear
    wstrb <= 4'h1;
    axi_write(`RXF_CFG_ADDR, 32'hFFFF_FFFF, r);
    axi_read(`RXF_CFG_ADDR, d, r);
    check("cfg byte strobe", d, 32'h0000_00FF);
    wstrb <= 4'hF;
    for (int i = 0; i < 64; i++)
    begin
      seed = lfsr(seed);
      c = {seed[31:13], i[4], i[3:0], seed[7:0]};
      if (i == 0) c = 32'hFFFF_FFFF;
      rx_en <= 1'b0;
      axi_write(`RXF_CFG_ADDR, c, r);
      check("cfg write resp", {30'h0, r}, {30'h0, `RESP_OKAY});
      axi_read(`RXF_CFG_ADDR, d, r);
      check("cfg readback", d, c & 32'h0000_DFFF);
      rx_en <= 1'b1;
      slow  <= i[5];
      axi_read(`RXF_STAT_ADDR, d, r);
      check("status receive_enable", {31'h0, d[2]}, 32'h1);
      send_burst(c & 32'h0000_DFFF);
      axi_read(`RXF_STAT_ADDR, d, r);
      check("status counters", {16'h0, d[23:8]}, {16'h0, exp_rej, exp_acc});
    end
    check("verdicts left", exp_q.size(), 32'h0);
    end_sim();
  end
endmodule
